/* File: verilog/bit_compare_decimal_decode.sv */
// Decode, length and cycle-count unit for bit clear, set and xor, compare and decimal add.
`timescale 1ns/1ps
`include "decode_defines.svh"
module bit_compare_decimal_decode
(
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Instruction from the fetch unit.
	input  wire logic        instr_valid,
	input  wire logic [3:0]  instr_format,
	input  wire logic        instr_size,
	input  wire logic        instr_imm_form,
	input  wire logic [3:0]  field_dst,
	input  wire logic [3:0]  field_src,
	input  wire logic [3:0]  quick_immediate_field,
	// Decoded result to the sequencer.
	output logic             dec_valid,
	output logic             dec_error,
	output logic             dec_word,
	output logic [2:0]       dec_length,
	output logic [2:0]       dec_cycles,
	output logic [3:0]       dst_mode,
	output logic [1:0]       dst_index,
	output logic [3:0]       src_mode,
	output logic [1:0]       src_index,
	output logic [15:0]      quick_value
);

	// ----------------------------------------
	// Field decoders
	// ----------------------------------------
	operand_field_if dst_port ();
	operand_field_if src_port ();

	assign dst_port.field = field_dst;
	assign src_port.field = field_src;

	operand_field_decode dst_decode (.port(dst_port));
	operand_field_decode src_decode (.port(src_port));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Extra displacement bytes an operand class adds after the opcode.
	function automatic logic [2:0] ext_bytes(input decode_pkg::mode_type m);
		logic [2:0] n;
		n = 3'h0;
		if (m == decode_pkg::mode_dsp8_addr || m == decode_pkg::mode_dsp8_base)
		begin
			n = 3'h1;
		end
		else if (m == decode_pkg::mode_dsp16_addr || m == decode_pkg::mode_dsp16_static ||
			m == decode_pkg::mode_abs16)
		begin
			n = 3'h2;
		end
		return n;
	endfunction

	// True when the operand class reads memory.
	function automatic logic is_memory(input decode_pkg::mode_type m);
		return m == decode_pkg::mode_indirect || m == decode_pkg::mode_dsp8_addr ||
			m == decode_pkg::mode_dsp8_base || m == decode_pkg::mode_dsp16_addr ||
			m == decode_pkg::mode_dsp16_static || m == decode_pkg::mode_abs16;
	endfunction

	// ----------------------------------------
	// Next-value decode
	// ----------------------------------------
	logic                 next_error;
	logic                 next_word;
	logic [2:0]           next_length;
	logic [2:0]           next_cycles;
	decode_pkg::mode_type next_dst_mode;
	logic [1:0]           next_dst_index;
	decode_pkg::mode_type next_src_mode;
	logic [1:0]           next_src_index;

	// Pick classes and costs for the presented format.
	always_comb
	begin
		next_error     = 1'b0;
		next_word      = 1'b0;
		next_length    = 3'h0;
		next_cycles    = 3'h0;
		next_dst_mode  = decode_pkg::mode_none;
		next_dst_index = 2'h0;
		next_src_mode  = decode_pkg::mode_none;
		next_src_index = 2'h0;
		case (instr_format)
			`FMT_BIT_CLEAR, `FMT_BIT_SET, `FMT_BIT_XOR:
			begin
				next_dst_mode  = dst_port.mode;
				next_dst_index = dst_port.index;
				unique case (dst_port.mode)
					decode_pkg::mode_data_reg, decode_pkg::mode_addr_reg:
					begin
						next_length = `BIT_LEN_REG;
						next_cycles = `BIT_CYC_REG;
					end
					decode_pkg::mode_indirect:
					begin
						next_length = `BIT_LEN_IND;
						next_cycles = `BIT_CYC_ADDR_MEM;
					end
					decode_pkg::mode_dsp8_addr:
					begin
						next_length = `BIT_LEN_BASE8;
						next_cycles = `BIT_CYC_ADDR_MEM;
					end
					decode_pkg::mode_dsp8_base:
					begin
						next_length = `BIT_LEN_BASE8;
						next_cycles = `BIT_CYC_BASE;
					end
					decode_pkg::mode_dsp16_addr:
					begin
						next_length = `BIT_LEN_BASE16;
						next_cycles = `BIT_CYC_ADDR_MEM;
					end
					default:
					begin
						next_length = `BIT_LEN_BASE16;
						next_cycles = `BIT_CYC_BASE;
					end
				endcase
			end
			`FMT_CMP_IMM:
			begin
				next_word      = instr_size;
				next_dst_mode  = dst_port.mode;
				next_dst_index = dst_port.index;
				next_src_mode  = decode_pkg::mode_immediate;
				next_length    = 3'(`CMP_IMM_LEN_BASE + ext_bytes(dst_port.mode) + {2'h0, instr_size});
				next_cycles    = is_memory(dst_port.mode) ? `CMP_IMM_CYC_MEM : `CMP_IMM_CYC_REG;
			end
			`FMT_CMP_QUICK:
			begin
				next_word      = instr_size;
				next_dst_mode  = dst_port.mode;
				next_dst_index = dst_port.index;
				next_src_mode  = decode_pkg::mode_immediate;
				next_length    = 3'(`CMP_Q_LEN_BASE + ext_bytes(dst_port.mode));
				next_cycles    = is_memory(dst_port.mode) ? `CMP_Q_CYC_MEM : `CMP_Q_CYC_REG;
			end
			`FMT_CMP_SHORT_IMM:
			begin
				next_src_mode = decode_pkg::mode_immediate;
				case (field_dst[2:0])
					3'h3:
					begin
						next_dst_mode  = decode_pkg::mode_data_reg;
						next_dst_index = 2'h1;
					end
					3'h4: next_dst_mode = decode_pkg::mode_data_reg;
					3'h5: next_dst_mode = decode_pkg::mode_dsp8_base;
					3'h6:
					begin
						next_dst_mode  = decode_pkg::mode_dsp8_base;
						next_dst_index = 2'h1;
					end
					3'h7: next_dst_mode = decode_pkg::mode_abs16;
					default: next_error = 1'b1;
				endcase
				next_length = 3'(`CMP_S_LEN_BASE + ext_bytes(next_dst_mode));
				next_cycles = is_memory(next_dst_mode) ? `CMP_S_CYC_MEM : `CMP_S_CYC_REG;
				if (next_error)
				begin
					next_dst_mode = decode_pkg::mode_none;
					next_src_mode = decode_pkg::mode_none;
					next_length   = 3'h0;
					next_cycles   = 3'h0;
				end
			end
			`FMT_CMP_GEN:
			begin
				next_word      = instr_size;
				next_dst_mode  = dst_port.mode;
				next_dst_index = dst_port.index;
				next_src_mode  = src_port.mode;
				next_src_index = src_port.index;
				next_length    = 3'(`CMP_G_LEN_BASE + ext_bytes(src_port.mode) + ext_bytes(dst_port.mode));
				next_cycles    = 3'(`CMP_G_CYC_BASE + {2'h0, is_memory(src_port.mode)} +
					{2'h0, is_memory(dst_port.mode)});
			end
			`FMT_CMP_SHORT_ACC:
			begin
				next_dst_mode  = decode_pkg::mode_data_reg;
				next_dst_index = {1'b0, field_dst[0]};
				unique case (field_src[1:0])
					2'h0:
					begin
						next_src_mode  = decode_pkg::mode_data_reg;
						next_src_index = {1'b0, ~field_dst[0]};
					end
					2'h1: next_src_mode = decode_pkg::mode_dsp8_base;
					2'h2:
					begin
						next_src_mode  = decode_pkg::mode_dsp8_base;
						next_src_index = 2'h1;
					end
					2'h3: next_src_mode = decode_pkg::mode_abs16;
				endcase
				next_length = 3'(`CMP_A_LEN_BASE + ext_bytes(next_src_mode));
				next_cycles = is_memory(next_src_mode) ? `CMP_A_CYC_MEM : `CMP_A_CYC_REG;
			end
			`FMT_DEC_ADD_CARRY, `FMT_DEC_ADD:
			begin
				next_word     = instr_size;
				next_dst_mode = decode_pkg::mode_data_reg;
				next_cycles   = `DEC_CYC;
				if (instr_imm_form)
				begin
					next_src_mode = decode_pkg::mode_immediate;
					next_length   = instr_size ? `DEC_LEN_WORD_IMM : `DEC_LEN_BYTE_IMM;
				end
				else
				begin
					next_src_mode  = decode_pkg::mode_data_reg;
					next_src_index = 2'h1;
					next_length    = `DEC_LEN_REG;
				end
			end
			default: next_error = 1'b1;
		endcase
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	// Every result field loads in the same edge so the sequencer sees one coherent record.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			dec_valid   <= 1'b0;
			dec_error   <= 1'b0;
			dec_word    <= 1'b0;
			dec_length  <= 3'h0;
			dec_cycles  <= 3'h0;
			dst_mode    <= 4'h0;
			dst_index   <= 2'h0;
			src_mode    <= 4'h0;
			src_index   <= 2'h0;
		end
		else
		begin
			dec_valid   <= instr_valid;
			dec_error   <= instr_valid & next_error;
			dec_word    <= next_word;
			dec_length  <= next_length;
			dec_cycles  <= next_cycles;
			dst_mode    <= 4'(next_dst_mode);
			dst_index   <= next_dst_index;
			src_mode    <= 4'(next_src_mode);
			src_index   <= next_src_index;
		end
	end

	// Quick immediate sign extension, kept in its own register.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			quick_value <= 16'h0000;
		end
		else
		begin
			quick_value <= {{12{quick_immediate_field[3]}}, quick_immediate_field};
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	chk_bit_register_cost: assert property (
		instr_valid && instr_format == `FMT_BIT_SET && field_dst[3:2] == 2'h0
		|=> dec_length == 3'h3 && dec_cycles == 3'h3 && dst_mode == 4'(decode_pkg::mode_data_reg))
		else $error("bit op register cost wrong");
	chk_bit_indirect_cost: assert property (
		instr_valid && instr_format == `FMT_BIT_CLEAR && field_dst[3:1] == 3'h3
		|=> dec_length == 3'h2 && dec_cycles == 3'h7 && dst_index == {1'b0, $past(field_dst[0])})
		else $error("bit op indirect decode wrong");
	chk_bit_absolute: assert property (
		instr_valid && instr_format == `FMT_BIT_XOR && field_dst == 4'hF
		|=> dst_mode == 4'(decode_pkg::mode_abs16) && dec_length == 3'h4 && dec_cycles == 3'h4)
		else $error("bit op absolute decode wrong");
	chk_imm_word_length: assert property (
		instr_valid && instr_format == `FMT_CMP_IMM && field_dst == 4'hC && instr_size
		|=> dec_length == 3'h6 && dec_cycles == 3'h4 && dec_word)
		else $error("word immediate compare length wrong");
	chk_imm_reg_cost: assert property (
		instr_valid && instr_format == `FMT_CMP_IMM && field_dst[3:2] == 2'h0 && !instr_size
		|=> dec_length == 3'h3 && dec_cycles == 3'h2)
		else $error("immediate compare register cost wrong");
	chk_quick_sign: assert property (
		quick_immediate_field[3] |=> quick_value[15:4] == 12'hFFF && quick_value[3:0] == $past(quick_immediate_field))
		else $error("quick immediate not sign extended");
	chk_quick_dsp8_cost: assert property (
		instr_valid && instr_format == `FMT_CMP_QUICK && field_dst[3:2] == 2'h2
		|=> dec_length == 3'h3 && dec_cycles == 3'h3)
		else $error("quick compare displacement cost wrong");
	chk_short_illegal: assert property (
		instr_valid && instr_format == `FMT_CMP_SHORT_IMM && field_dst[2:0] < 3'h3
		|=> dec_valid && dec_error && dec_length == 3'h0)
		else $error("short immediate illegal destination not flagged");
	chk_gen_both_memory: assert property (
		instr_valid && instr_format == `FMT_CMP_GEN && field_src == 4'hF && field_dst == 4'hE
		|=> dec_length == 3'h6 && dec_cycles == 3'h4)
		else $error("source destination compare cost wrong");
	chk_acc_other_byte: assert property (
		instr_valid && instr_format == `FMT_CMP_SHORT_ACC && field_src[1:0] == 2'h0
		|=> src_index == {1'b0, ~dst_index[0]} && dec_length == 3'h1 && dec_cycles == 3'h2)
		else $error("short accumulator compare wrong");
	chk_decimal_cycles: assert property (
		instr_valid && (instr_format == `FMT_DEC_ADD || instr_format == `FMT_DEC_ADD_CARRY)
		|=> dec_cycles == 3'h5 && dec_length == ($past(instr_imm_form) ? ($past(instr_size) ? 3'h4 : 3'h3) : 3'h2))
		else $error("decimal add cost wrong");
	chk_result_together: assert property (
		dec_valid && !dec_error |-> dec_length != 3'h0 && dec_cycles != 3'h0)
		else $error("valid result without length or cycles");

	cov_bit_base16: cover property (instr_valid && instr_format == `FMT_BIT_SET && field_dst == 4'hD);
	cov_gen_mixed: cover property (instr_valid && instr_format == `FMT_CMP_GEN && field_src == 4'h6 ##1 dec_valid);
	cov_decimal_word: cover property (instr_valid && instr_format == `FMT_DEC_ADD_CARRY && instr_size);
	cov_back_to_back: cover property (instr_valid ##1 instr_valid ##1 dec_valid);

endmodule

/* File: verilog/decode_defines.svh */
// Constants for the bit, compare and decimal-add decode slice.
// How it works
// - Bit-op codes 0000-0011 pick data registers 0-3; 0100/0101 pick address registers.
// - Bit-op 0110/0111 indirect, 1000-1011 8-bit base, 1100/1101 16-bit base on An.
// - Bit-op 1110 is 16-bit base on static base; 1111 is absolute 16-bit.
// - Bit ops cost 3/3, 2/7, 3/7, 3/4, 4/7 or 4/4 by mode.
// - General compare size bit: 0 byte, 1 word; 0000-0011 registers, 1000-1011 8-bit displacement.
// - General compare 0100-0111 An and indirect, 1100-1110 16-bit displacement, 1111 absolute.
// - Immediate compare costs 3/2, 3/4, 4/4 or 5/4 at byte size.
// - Word-size immediate compare adds one immediate byte to the length.
// - Quick immediate is four-bit two's complement, -8 to +7.
// - Quick compare costs 2/1, 2/3, 3/3 or 4/3 by destination mode.
// - Short immediate destination: 011 high, 100 low, 101 static, 110 frame, 111 absolute.
// - Short immediate compare costs 2/1, 3/3 or 4/3.
// - Source/destination compare: 2, 3 or 4 cycles by memory operands; 2-6 bytes.
// - Short accumulator compare: 2-bit source, 1-bit destination byte select.
// - Short accumulator compare costs 1/2, 2/3 or 3/3.
// - Decimal adds take 5 cycles; 3, 4 or 2 bytes by form.
`ifndef DECODE_DEFINES_SVH
`define DECODE_DEFINES_SVH

// Instruction format codes presented by the fetch unit.
`define FMT_BIT_CLEAR     4'h0
`define FMT_BIT_SET       4'h1
`define FMT_BIT_XOR       4'h2
`define FMT_CMP_IMM       4'h3
`define FMT_CMP_QUICK     4'h4
`define FMT_CMP_SHORT_IMM 4'h5
`define FMT_CMP_GEN       4'h6
`define FMT_CMP_SHORT_ACC 4'h7
`define FMT_DEC_ADD_CARRY 4'h8
`define FMT_DEC_ADD       4'h9

// Bit operation lengths and cycles.
`define BIT_LEN_REG       3'h3
`define BIT_CYC_REG       3'h3
`define BIT_LEN_IND       3'h2
`define BIT_CYC_ADDR_MEM  3'h7
`define BIT_LEN_BASE8     3'h3
`define BIT_CYC_BASE      3'h4
`define BIT_LEN_BASE16    3'h4

// Compare lengths and cycles.
`define CMP_IMM_LEN_BASE  3'h3
`define CMP_IMM_CYC_REG   3'h2
`define CMP_IMM_CYC_MEM   3'h4
`define CMP_Q_LEN_BASE    3'h2
`define CMP_Q_CYC_REG     3'h1
`define CMP_Q_CYC_MEM     3'h3
`define CMP_S_LEN_BASE    3'h2
`define CMP_S_CYC_REG     3'h1
`define CMP_S_CYC_MEM     3'h3
`define CMP_G_LEN_BASE    3'h2
`define CMP_G_CYC_BASE    3'h2
`define CMP_A_LEN_BASE    3'h1
`define CMP_A_CYC_REG     3'h2
`define CMP_A_CYC_MEM     3'h3

// Decimal add lengths and cycles.
`define DEC_CYC           3'h5
`define DEC_LEN_BYTE_IMM  3'h3
`define DEC_LEN_WORD_IMM  3'h4
`define DEC_LEN_REG       3'h2

`endif

/* File: verilog/decode_pkg.sv */
// Types shared by the decode slice.
package decode_pkg;

	// Operand addressing class produced by the field decoder.
	typedef enum logic [3:0] {
		mode_none,
		mode_data_reg,
		mode_addr_reg,
		mode_indirect,
		mode_dsp8_addr,
		mode_dsp8_base,
		mode_dsp16_addr,
		mode_dsp16_static,
		mode_abs16,
		mode_immediate
	} mode_type;

endpackage

/* File: verilog/operand_field_if.sv */
// Carrier between a four-bit operand field and its decoded class.
`timescale 1ns/1ps
interface operand_field_if;
	logic                  [3:0] field;
	decode_pkg::mode_type        mode;
	logic                  [1:0] index;

	modport decode (input field, output mode, output index);
	modport user   (output field, input mode, input index);
endinterface

/* File: verilog/operand_field_decode.sv */
// Decoder of the four-bit general operand field shared by bit ops and compares.
`timescale 1ns/1ps
`include "decode_defines.svh"
module operand_field_decode
(
	// Field in, class out.
	operand_field_if.decode port
);

	// Classify the field; index names the register or the base register.
	always_comb
	begin
		port.index = port.field[1:0];
		unique case (port.field[3:1])
			3'h0, 3'h1: port.mode = decode_pkg::mode_data_reg;
			3'h2:       port.mode = decode_pkg::mode_addr_reg;
			3'h3:       port.mode = decode_pkg::mode_indirect;
			3'h4:       port.mode = decode_pkg::mode_dsp8_addr;
			3'h5:       port.mode = decode_pkg::mode_dsp8_base;
			3'h6:       port.mode = decode_pkg::mode_dsp16_addr;
			3'h7:       port.mode = port.field[0] ? decode_pkg::mode_abs16 : decode_pkg::mode_dsp16_static;
		endcase
		// Address-register, indirect and base classes report 0 for the first and 1 for the second register.
		if (port.field[3] || port.field[2])
		begin
			port.index = {1'b0, port.field[0]};
		end
	end

endmodule

/* File: testbench/fetch_model.sv */
// Behavioural model of the fetch unit that hands instructions to the decoder.
`timescale 1ns/1ps
module fetch_model
(
	// Instruction towards the decoder.
	output logic       instr_valid,
	output logic [3:0] instr_format,
	output logic       instr_size,
	output logic       instr_imm_form,
	output logic [3:0] field_dst,
	output logic [3:0] field_src,
	output logic [3:0] quick_immediate_field
);
	// --------------------------------------------------------------
	// Presentation
	// --------------------------------------------------------------

	// An idle fetch unit shows nothing valid but still drives every field.
	initial
	begin
		instr_valid = 1'b0;
		instr_format = 4'h0;
		instr_size = 1'b0;
		instr_imm_form = 1'b0;
		field_dst = 4'h0;
		field_src = 4'h0;
		quick_immediate_field = 4'h0;
	end

	// Places one instruction; callers use it just after a rising edge and hold it a full cycle.
	task automatic present(input logic v, input logic [3:0] fmt, input logic sz, input logic im,
		input logic [3:0] d, input logic [3:0] s, input logic [3:0] q);
		instr_valid = v;
		instr_format = fmt;
		instr_size = sz;
		instr_imm_form = im;
		field_dst = d;
		field_src = s;
		quick_immediate_field = q;
	endtask
endmodule

/* File: testbench/bit_compare_decimal_decode_test.sv */
// Self-checking testbench of the bit, compare and decimal-add decoder.
`timescale 1ns/1ps
`define CHECK(nm, ex, ac) \
	begin \
		num_checks++; \
		if ((ac) !== (ex)) \
		begin \
			failures++; \
			$display("mismatch %s expected %0h seen %0h", nm, ex, ac); \
		end \
	end
module bit_compare_decimal_decode_test;
	typedef struct {
		logic       err, wd, dc, sc, sic;
		logic [2:0] len, cyc;
		logic [3:0] dm, sm;
		logic [1:0] di, si;
	} exp_type;

	logic        clk_sys;
	logic        resetn;
	logic        instr_valid, instr_size, instr_imm_form;
	logic [3:0]  instr_format, field_dst, field_src, quick_immediate_field;
	logic        dec_valid, dec_error, dec_word;
	logic [2:0]  dec_length, dec_cycles;
	logic [3:0]  dst_mode, src_mode;
	logic [1:0]  dst_index, src_index;
	logic [15:0] quick_value;
	int          failures;
	int          num_checks;

	// --------------------------------------------------------------
	// Structure
	// --------------------------------------------------------------

	// Free-running 100 MHz clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	bit_compare_decimal_decode u_bit_compare_decimal_decode (.clk_sys(clk_sys), .resetn(resetn),
		.instr_valid(instr_valid), .instr_format(instr_format), .instr_size(instr_size),
		.instr_imm_form(instr_imm_form), .field_dst(field_dst), .field_src(field_src),
		.quick_immediate_field(quick_immediate_field), .dec_valid(dec_valid), .dec_error(dec_error),
		.dec_word(dec_word), .dec_length(dec_length), .dec_cycles(dec_cycles), .dst_mode(dst_mode),
		.dst_index(dst_index), .src_mode(src_mode), .src_index(src_index), .quick_value(quick_value));

	fetch_model u_fetch_model (.instr_valid(instr_valid), .instr_format(instr_format),
		.instr_size(instr_size), .instr_imm_form(instr_imm_form), .field_dst(field_dst),
		.field_src(field_src), .quick_immediate_field(quick_immediate_field));

	// --------------------------------------------------------------
	// Expected decode
	// --------------------------------------------------------------

	// Class of a four-bit general operand field; the static-base and absolute cases (1110, 1111) carry no index.
	function automatic void field_mode(input logic [3:0] f, output logic [3:0] m, output logic [1:0] i,
		output logic c);
		c = 1'b1;
		i = {1'b0, f[0]};
		case (f[3:1])
			3'h0, 3'h1:
			begin
				m = decode_pkg::mode_data_reg;
				i = f[1:0];
			end
			3'h2: m = decode_pkg::mode_addr_reg;
			3'h3: m = decode_pkg::mode_indirect;
			3'h4: m = decode_pkg::mode_dsp8_addr;
			3'h5: m = decode_pkg::mode_dsp8_base;
			3'h6: m = decode_pkg::mode_dsp16_addr;
			default:
			begin
				m = f[0] ? decode_pkg::mode_abs16 : decode_pkg::mode_dsp16_static;
				c = 1'b0;
			end
		endcase
	endfunction

	// Displacement bytes that a general operand field adds to the length.
	function automatic logic [2:0] ext(input logic [3:0] f);
		return f < 4'h8 ? 3'h0 : f < 4'hC ? 3'h1 : 3'h2;
	endfunction

	// Full expected result of one instruction.
	function automatic exp_type expect_of(input logic [3:0] fmt, input logic sz, input logic im,
		input logic [3:0] d, input logic [3:0] s);
		exp_type e;
		e = '{default: 0};
		e.dc = 1'b1;
		e.sc = 1'b1;
		e.sic = 1'b1;
		case (fmt)
			4'h0, 4'h1, 4'h2:
			begin
				field_mode(d, e.dm, e.di, e.dc);
				e.len = (d < 4'h6 || (d > 4'h7 && d < 4'hC)) ? 3'h3 : d < 4'h8 ? 3'h2 : 3'h4;
				e.cyc = d < 4'h6 ? 3'h3 : (d < 4'hA || d == 4'hC || d == 4'hD) ? 3'h7 : 3'h4;
			end
			4'h3, 4'h4:
			begin
				field_mode(d, e.dm, e.di, e.dc);
				e.wd = sz;
				e.len = fmt == 4'h3 ? 3'h3 + ext(d) + {2'h0, sz} : 3'h2 + ext(d);
				e.cyc = fmt == 4'h3 ? (d < 4'h6 ? 3'h2 : 3'h4) : (d < 4'h6 ? 3'h1 : 3'h3);
				e.sm = decode_pkg::mode_immediate;
				e.sic = 1'b0;
			end
			4'h5:
			begin
				e.sic = 1'b0;
				case (d[2:0])
					3'h3, 3'h4: e.dm = decode_pkg::mode_data_reg;
					3'h5, 3'h6: e.dm = decode_pkg::mode_dsp8_base;
					3'h7: e.dm = decode_pkg::mode_abs16;
					default: e.err = 1'b1;
				endcase
				e.di = d[2:0] < 3'h5 ? {1'b0, ~d[2]} : {1'b0, d[1]};
				e.dc = !e.err && d[2:0] != 3'h7;
				e.len = e.err ? 3'h0 : d[2:0] < 3'h5 ? 3'h2 : d[2:0] < 3'h7 ? 3'h3 : 3'h4;
				e.cyc = e.err ? 3'h0 : d[2:0] < 3'h5 ? 3'h1 : 3'h3;
				e.sm = e.err ? decode_pkg::mode_none : decode_pkg::mode_immediate;
			end
			4'h6:
			begin
				field_mode(d, e.dm, e.di, e.dc);
				field_mode(s, e.sm, e.si, e.sic);
				e.wd = sz;
				e.len = 3'h2 + ext(s) + ext(d);
				e.cyc = 3'h2 + {2'h0, s > 4'h5} + {2'h0, d > 4'h5};
			end
			4'h7:
			begin
				e.dm = decode_pkg::mode_data_reg;
				e.di = {1'b0, d[0]};
				e.sm = s[1:0] == 2'h0 ? decode_pkg::mode_data_reg :
					s[1:0] == 2'h3 ? decode_pkg::mode_abs16 : decode_pkg::mode_dsp8_base;
				e.si = s[1:0] == 2'h0 ? {1'b0, ~d[0]} : {1'b0, s[1]};
				e.sic = s[1:0] != 2'h3;
				e.len = s[1:0] == 2'h0 ? 3'h1 : s[1:0] == 2'h3 ? 3'h3 : 3'h2;
				e.cyc = s[1:0] == 2'h0 ? 3'h2 : 3'h3;
			end
			4'h8, 4'h9:
			begin
				e.dm = decode_pkg::mode_data_reg;
				e.wd = sz;
				e.cyc = 3'h5;
				e.len = im ? 3'h3 + {2'h0, sz} : 3'h2;
				e.sm = im ? decode_pkg::mode_immediate : decode_pkg::mode_data_reg;
				e.si = 2'h1;
				e.sic = ~im;
			end
			default: e.err = 1'b1;
		endcase
		return e;
	endfunction

	// --------------------------------------------------------------
	// Drivers, comparison and scenarios
	// --------------------------------------------------------------

	// Lets the presenting edge pass and compares every result but quick_value in that single cycle, indexes only where defined.
	task automatic check_out(input exp_type e);
		@(posedge clk_sys);
		#1;
		`CHECK("valid", 1'b1, dec_valid)
		`CHECK("error", e.err, dec_error)
		`CHECK("word", e.wd, dec_word)
		`CHECK("length", e.len, dec_length)
		`CHECK("cycles", e.cyc, dec_cycles)
		`CHECK("dst_mode", e.dm, dst_mode)
		if (e.dc) `CHECK("dst_index", e.di, dst_index)
		if (e.sc) `CHECK("src_mode", e.sm, src_mode)
		if (e.sic) `CHECK("src_index", e.si, src_index)
	endtask

	// Presents one instruction and judges its decode; successive calls run back to back.
	task automatic run_case(input logic [3:0] fmt, input logic sz, input logic im, input logic [3:0] d,
		input logic [3:0] s, input logic [3:0] q);
		u_fetch_model.present(1'b1, fmt, sz, im, d, s, q);
		check_out(expect_of(fmt, sz, im, d, s));
	endtask

	// All three bit formats over every operand code, with the size line set to catch leaks.
	task automatic test_bit_ops();
		for (int f = 0; f < 48; f++)
			run_case(4'(f / 16), 1'b1, 1'b0, 4'(f), 4'h0, 4'h0);
	endtask

	// General immediate compare at both sizes over every destination.
	task automatic test_cmp_imm();
		for (int f = 0; f < 32; f++)
			run_case(4'h3, f[4], 1'b0, 4'(f), 4'h0, 4'h0);
	endtask

	// Quick compare over every destination and every immediate code.
	task automatic test_cmp_quick();
		logic [3:0] q;
		for (int f = 0; f < 16; f++)
		begin
			q = 4'hF - 4'(f);
			run_case(4'h4, f[0], 1'b0, 4'(f), 4'h0, q);
			`CHECK("quick", {{12{q[3]}}, q}, quick_value)
		end
	endtask

	// Short immediate compare over all eight destination codes, reserved ones included.
	task automatic test_cmp_short_imm();
		for (int f = 0; f < 8; f++)
			run_case(4'h5, 1'b1, 1'b0, {1'b1, 3'(f)}, 4'h0, 4'h0);
	endtask

	// Source/destination compare over every pair of operand codes.
	task automatic test_cmp_gen();
		for (int f = 0; f < 256; f++)
			run_case(4'h6, f[4], 1'b0, 4'(f), 4'(f / 16), 4'h0);
	endtask

	// Short accumulator compare over all sources and both destination bytes.
	task automatic test_cmp_short_acc();
		for (int f = 0; f < 8; f++)
			run_case(4'h7, 1'b1, 1'b0, {3'h7, f[2]}, {2'h3, 2'(f)}, 4'h0);
	endtask

	// Both decimal adds in all four forms, then the undefined format codes.
	task automatic test_decimal_and_illegal();
		for (int f = 0; f < 8; f++)
			run_case(4'(8 + f / 4), f[1], f[0], 4'h0, 4'h0, 4'h0);
		for (int f = 10; f < 16; f++)
			run_case(4'(f), 1'b1, 1'b0, 4'h3, 4'h3, 4'h0);
	endtask

	// An idle cycle and a reset in mid-run must both hide the presented instruction.
	task automatic test_idle_and_reset();
		u_fetch_model.present(1'b0, 4'h3, 1'b1, 1'b0, 4'hC, 4'h0, 4'h0);
		@(posedge clk_sys);
		#1;
		`CHECK("idle valid", 1'b0, dec_valid)
		u_fetch_model.present(1'b1, 4'h3, 1'b1, 1'b0, 4'hC, 4'h0, 4'h0);
		resetn = 1'b0;
		@(posedge clk_sys);
		#1;
		`CHECK("reset valid", 1'b0, dec_valid)
		`CHECK("reset length", 3'h0, dec_length)
		resetn = 1'b1;
		@(posedge clk_sys);
		#1;
		run_case(4'h3, 1'b1, 1'b0, 4'hC, 4'h0, 4'h0);
	endtask

	// Reports the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog sized well above the few hundred cycles the scenarios need.
	initial
	begin
		#100000;
		failures++;
		print_verdict();
	end

	// Main sequence: reset with a valid instruction waiting, then every scenario.
	initial
	begin
		failures = 0;
		num_checks = 0;
		resetn = 1'b0;
		#1;
		u_fetch_model.present(1'b1, 4'h3, 1'b1, 1'b0, 4'hC, 4'h0, 4'h0);
		repeat (16) @(posedge clk_sys);
		#1;
		`CHECK("reset valid", 1'b0, dec_valid)
		`CHECK("reset cycles", 3'h0, dec_cycles)
		resetn = 1'b1;
		@(posedge clk_sys);
		#1;
		test_bit_ops();
		test_cmp_imm();
		test_cmp_quick();
		test_cmp_short_imm();
		test_cmp_gen();
		test_cmp_short_acc();
		test_decimal_and_illegal();
		test_idle_and_reset();
		print_verdict();
	end
endmodule
